//--- cdp_pkg.sv
package cdp_pkg;
    localparam int CLK_MHZ = 40;
    localparam int EXEC_TIME_NS = 600;
    localparam logic [7:0] EXEC_CYC = 8'((EXEC_TIME_NS * CLK_MHZ + 999) / 1000);

    // apb map
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SHIFT = 8'h08;
    localparam logic [7:0] OFS_PEEK = 8'h0C;
    localparam logic [7:0] OFS_LAST_CMD = 8'h10;

    // cfg fields
    localparam int CFG_PORT_EN_BIT = 0;
    localparam int CFG_EXEC_LSB = 8;
    localparam logic CFG_PORT_EN_RST = 1'b1;

    // status fields
    localparam int ST_AC_LSB = 0;
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_TGT_BIT = 8;
    localparam int ST_WIDTH_BIT = 9;
    localparam int ST_LINES_BIT = 10;
    localparam int ST_DIR_BIT = 11;
    localparam int ST_SHIFT_EN_BIT = 12;
    localparam int ST_SERIAL_BIT = 13;
    localparam int ST_STYLE_BIT = 14;

    // instruction decode
    localparam int INS_DD_BIT = 7;
    localparam logic [1:0] INS_CG_CODE = 2'h1;
    localparam logic [2:0] INS_FUNC_CODE = 3'h1;
    localparam int INS_WIDTH_BIT = 4;
    localparam int INS_LINES_BIT = 3;
    localparam logic [5:0] INS_ENTRY_CODE = 6'h01;
    localparam int INS_DIR_BIT = 1;
    localparam int INS_SHIFT_BIT = 0;

    // reset values of mode bits
    localparam logic WIDTH_RST = 1'b1;
    localparam logic LINES_RST = 1'b0;
    localparam logic DIR_RST = 1'b1;
    localparam logic SHIFT_EN_RST = 1'b0;

    // memory sizes and serial frame
    localparam int DD_DEPTH = 128;
    localparam int CG_DEPTH = 64;
    localparam logic [3:0] SER_LAST = 4'h9;

    typedef enum logic {CDP_TGT_DISPLAY, CDP_TGT_GLYPH} cdp_tgt_e;
    typedef enum logic {CDP_NIB_HIGH, CDP_NIB_LOW} cdp_nib_e;
endpackage

//--- cdp_host_port.sv
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module cdp_host_port
    import cdp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // bus selection pins
    input wire logic port_serial_select_in,
    input wire logic bus_style_select_in,
    // parallel bus
    input wire logic reg_select_in,
    input wire logic read_not_write_in,
    input wire logic strobe_e_in,
    input wire logic wr_n_in,
    input wire logic rd_n_in,
    input wire logic [7:0] db_in,
    output logic [7:0] db_out,
    output logic [7:0] db_oe_n_out,
    // serial bus
    input wire logic ser_cs_n_in,
    input wire logic ser_clk_in,
    input wire logic ser_data_in,
    output logic ser_data_out,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // status
    output logic busy_out
);
    localparam int NPIN = 18;

    logic [NPIN-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
    logic ser_sel, style68, rs_s, rw_s, e_s, e_p, wrn_s, wrn_p, rdn_s, rdn_p;
    logic csn_s, sclk_s, sclk_p, sdi_s;
    logic [7:0] db_s;
    logic par_en, wr_end, rd_end, rd_act;
    logic wr_go, rd_go, go_rs;
    logic [7:0] go_byte;
    cdp_nib_e nib_r;
    logic [3:0] hi_r;
    logic [3:0] ser_cnt_r;
    logic [9:0] ser_sh_r;
    logic ser_rd_r, ser_out_r, ser_rs_r;
    logic [6:0] ac_r, ac_nxt, ac_step;
    cdp_tgt_e tgt_r, tgt_nxt;
    logic width_r, lines_r, dir_r, shift_en_r;
    logic [6:0] shift_r;
    logic [7:0] busy_cnt_r, exec_cyc_r, rd_buf_r, last_cmd_r, peek_addr_r;
    logic busy_r, port_en_r, exec;
    logic [7:0] dd_mem [0:DD_DEPTH-1];
    logic [7:0] cg_mem [0:CG_DEPTH-1];
    logic [7:0] rd_val, db_r;
    logic [31:0] prdata_r;
    logic err_r;

    // every pin passes two flops; the third stage only feeds edge detectors
    always_ff @(posedge clk_in) begin
        pin_s1_r <= {port_serial_select_in, bus_style_select_in, reg_select_in, read_not_write_in,
                     strobe_e_in, wr_n_in, rd_n_in, db_in, ser_cs_n_in, ser_clk_in, ser_data_in};
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
    end

    assign {ser_sel, style68, rs_s, rw_s, e_s, wrn_s, rdn_s, db_s, csn_s, sclk_s, sdi_s} = pin_s2_r;
    assign e_p = pin_s3_r[13];
    assign wrn_p = pin_s3_r[12];
    assign rdn_p = pin_s3_r[11];
    assign sclk_p = pin_s3_r[1];

    // strobe style and serial selection come from the pins
    assign par_en = port_en_r && !ser_sel;
    always_comb begin
        if (style68) begin
            wr_end = par_en && e_p && !e_s && !rw_s;
            rd_end = par_en && e_p && !e_s && rw_s;
            rd_act = par_en && e_s && rw_s;
        end else begin
            wr_end = par_en && !wrn_p && wrn_s;
            rd_end = par_en && !rdn_p && rdn_s;
            rd_act = par_en && !rdn_s;
        end
    end

    // nibble pairing: high half first, completion on the low half
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || width_r || !par_en) begin
            nib_r <= CDP_NIB_HIGH;
            hi_r <= 4'h0;
        end else if (wr_end || rd_end) begin
            if (nib_r == CDP_NIB_HIGH) begin
                nib_r <= CDP_NIB_LOW;
                hi_r <= db_s[7:4];
            end else begin
                nib_r <= CDP_NIB_HIGH;
            end
        end
    end

    // serial frame: rs, rw, then eight data bits, msb first
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || csn_s || !ser_sel || !port_en_r) begin
            ser_cnt_r <= 4'h0;
            ser_sh_r <= 10'h000;
            ser_rd_r <= 1'b0;
            ser_out_r <= 1'b0;
            ser_rs_r <= 1'b0;
        end else if (sclk_s && !sclk_p) begin
            ser_sh_r <= {ser_sh_r[8:0], sdi_s};
            ser_cnt_r <= (ser_cnt_r == SER_LAST) ? 4'h0 : ser_cnt_r + 4'h1;
            // rs must be kept apart: the shift register moves it on every bit
            if (ser_cnt_r == 4'h0) begin
                ser_rs_r <= sdi_s;
            end
            if (ser_cnt_r == 4'h1) begin
                ser_rd_r <= sdi_s;
            end
            if (ser_cnt_r >= 4'h1 && ser_cnt_r <= 4'h8) begin
                ser_out_r <= rd_val[3'(4'h8 - ser_cnt_r)];
            end
        end
    end

    // unified completion of one whole byte transfer
    always_comb begin
        wr_go = 1'b0;
        rd_go = 1'b0;
        go_rs = rs_s;
        go_byte = db_s;
        if (ser_sel) begin
            go_rs = ser_sh_r[8];
            go_byte = {ser_sh_r[6:0], sdi_s};
            if (port_en_r && !csn_s && sclk_s && !sclk_p && ser_cnt_r == SER_LAST) begin
                wr_go = !ser_sh_r[7];
                rd_go = ser_sh_r[7];
            end
        end else if (width_r) begin
            wr_go = wr_end;
            rd_go = rd_end;
        end else begin
            go_byte = {hi_r, db_s[7:4]};
            wr_go = wr_end && nib_r == CDP_NIB_LOW;
            rd_go = rd_end && nib_r == CDP_NIB_LOW;
        end
    end

    // a read of the data memory also moves the counter, so it counts as work
    assign exec = !busy_r && (wr_go || (rd_go && go_rs));

    // counter stepping wraps inside the selected memory
    always_comb begin
        ac_step = dir_r ? ac_r + 7'h01 : ac_r - 7'h01;
        if (tgt_r == CDP_TGT_GLYPH) begin
            ac_step[6] = 1'b0;
        end
        ac_nxt = ac_r;
        tgt_nxt = tgt_r;
        if (exec && wr_go && !go_rs) begin
            if (go_byte[INS_DD_BIT]) begin
                ac_nxt = go_byte[6:0];
                tgt_nxt = CDP_TGT_DISPLAY;
            end else if (go_byte[7:6] == INS_CG_CODE) begin
                ac_nxt = {1'b0, go_byte[5:0]};
                tgt_nxt = CDP_TGT_GLYPH;
            end
        end else if (exec) begin
            ac_nxt = ac_step;
        end
    end

    // instruction and data execution
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ac_r <= 7'h00;
            tgt_r <= CDP_TGT_DISPLAY;
            width_r <= WIDTH_RST;
            lines_r <= LINES_RST;
            dir_r <= DIR_RST;
            shift_en_r <= SHIFT_EN_RST;
            shift_r <= 7'h00;
            last_cmd_r <= 8'h00;
            rd_buf_r <= 8'h00;
        end else if (exec) begin
            ac_r <= ac_nxt;
            tgt_r <= tgt_nxt;
            // prefetch so a data read answers at once; zero from reset until the first executed transfer
            rd_buf_r <= (tgt_nxt == CDP_TGT_GLYPH) ? cg_mem[ac_nxt[5:0]] : dd_mem[ac_nxt];
            if (wr_go && !go_rs) begin
                last_cmd_r <= go_byte;
                if (go_byte[7:5] == INS_FUNC_CODE) begin
                    width_r <= go_byte[INS_WIDTH_BIT];
                    lines_r <= go_byte[INS_LINES_BIT];
                end
                if (go_byte[7:2] == INS_ENTRY_CODE) begin
                    dir_r <= go_byte[INS_DIR_BIT];
                    shift_en_r <= go_byte[INS_SHIFT_BIT];
                end
            end else if (wr_go && shift_en_r) begin
                shift_r <= dir_r ? shift_r - 7'h01 : shift_r + 7'h01;
            end
        end
    end

    // memories; the byte goes to the counter address, in the memory that the last address set selected
    always_ff @(posedge clk_in) begin
        if (exec && wr_go && go_rs) begin
            if (tgt_r == CDP_TGT_GLYPH) begin
                cg_mem[ac_r[5:0]] <= go_byte;
            end else begin
                dd_mem[ac_r] <= go_byte;
            end
        end
    end

    // busy holds for the execution time after any accepted work
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            busy_r <= 1'b0;
            busy_cnt_r <= 8'h00;
        end else if (exec) begin
            busy_r <= 1'b1;
            busy_cnt_r <= exec_cyc_r;
        end else if (busy_r) begin
            if (busy_cnt_r <= 8'h01) begin
                busy_r <= 1'b0;
            end
            busy_cnt_r <= busy_cnt_r - 8'h01;
        end
    end

    assign busy_out = busy_r;

    // read value: status byte or buffered memory byte
    assign rd_val = (ser_sel ? ser_rs_r : rs_s) ? rd_buf_r : {busy_r, ac_r};

    // parallel read drive; lines 0..3 stay off in four-bit mode
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            db_r <= 8'h00;
        end else if (width_r) begin
            db_r <= rd_val;
        end else begin
            db_r <= {(nib_r == CDP_NIB_HIGH) ? rd_val[7:4] : rd_val[3:0], 4'h0};
        end
    end

    assign db_out = db_r;
    assign db_oe_n_out = rd_act ? (width_r ? 8'h00 : 8'h0F) : 8'hFF;
    assign ser_data_out = ser_out_r && ser_rd_r;

    // apb slave: data prepared in setup, answered in the first access cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            port_en_r <= CFG_PORT_EN_RST;
            exec_cyc_r <= EXEC_CYC;
            peek_addr_r <= 8'h00;
            prdata_r <= 32'h0;
            err_r <= 1'b0;
        end else if (psel_in && !penable_in) begin
            prdata_r <= 32'h0;
            err_r <= 1'b0;
            case (paddr_in)
                OFS_CFG: prdata_r <= {16'h0, exec_cyc_r, 7'h0, port_en_r};
                OFS_STATUS: prdata_r <= {17'h0, style68, ser_sel, shift_en_r, dir_r, lines_r, width_r,
                                         tgt_r == CDP_TGT_GLYPH, busy_r, ac_r};
                OFS_SHIFT: prdata_r <= {25'h0, shift_r};
                OFS_PEEK: prdata_r <= {16'h0, peek_addr_r[7] ? cg_mem[peek_addr_r[5:0]] : dd_mem[peek_addr_r[6:0]],
                                       peek_addr_r};
                OFS_LAST_CMD: prdata_r <= {24'h0, last_cmd_r};
                default: err_r <= 1'b1;
            endcase
        end else if (psel_in && penable_in && pwrite_in) begin
            case (paddr_in)
                OFS_CFG: begin
                    port_en_r <= pwdata_in[CFG_PORT_EN_BIT];
                    exec_cyc_r <= pwdata_in[CFG_EXEC_LSB +: 8];
                end
                OFS_PEEK: peek_addr_r <= pwdata_in[7:0];
                default: ;
            endcase
        end
    end

    assign pready_out = psel_in && penable_in;
    assign prdata_out = prdata_r;
    assign pslverr_out = psel_in && penable_in && err_r;
endmodule

//--- cdp_checker.sv
`timescale 1ns/1ps
module cdp_checker
    import cdp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // pins
    input wire logic port_serial_select_in,
    input wire logic bus_style_select_in,
    input wire logic reg_select_in,
    input wire logic read_not_write_in,
    input wire logic strobe_e_in,
    input wire logic wr_n_in,
    input wire logic rd_n_in,
    input wire logic ser_cs_n_in,
    // outputs
    input wire logic [7:0] db_out,
    input wire logic [7:0] db_oe_n_out,
    input wire logic busy_out
);
    logic [7:0] busy_cnt_r;
    logic rd_strobe;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    assign rd_strobe = bus_style_select_in ? (strobe_e_in && read_not_write_in) : !rd_n_in;
    // length of the running busy stretch
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !busy_out) busy_cnt_r <= 8'h00;
        else busy_cnt_r <= busy_cnt_r + 8'h01;
    end
    a_busy_length: assert property ($fell(busy_out) |-> busy_cnt_r == EXEC_CYC)
        else $error("busy stretch length wrong");
    a_busy_cause: assert property ((!busy_out && !strobe_e_in && wr_n_in && rd_n_in && ser_cs_n_in)[*6] |=> !busy_out)
        else $error("busy without a transfer");
    // eight-bit status read only, the low lines tell the width apart
    a_status_flag: assert property ((rd_strobe && !reg_select_in && !db_oe_n_out[0] && $stable(busy_out))[*6]
        |-> db_out[7] == busy_out)
        else $error("status bit 7 is not busy");
    a_read_drive: assert property ((rd_strobe && !port_serial_select_in)[*4] |-> db_oe_n_out[7:4] == 4'h0)
        else $error("read strobe not driving");
    a_low_lines: assert property (db_oe_n_out[3:0] != 4'hF |-> db_oe_n_out[7:4] == 4'h0)
        else $error("low lines driven alone");
    a_bus_release: assert property ((!strobe_e_in && rd_n_in)[*5] |-> db_oe_n_out == 8'hFF)
        else $error("bus held after read");
    a_serial_quiet: assert property (port_serial_select_in[*4] |-> db_oe_n_out == 8'hFF)
        else $error("parallel read while serial");
    a_serial_nobusy: assert property ((port_serial_select_in && ser_cs_n_in && !busy_out)[*8] |=> !busy_out)
        else $error("parallel write while serial");
    c_busy: cover property ($rose(busy_out));
    c_nibble_read: cover property (db_oe_n_out == 8'h0F);
    c_serial: cover property (port_serial_select_in && !strobe_e_in ##1 strobe_e_in);
endmodule

bind cdp_host_port cdp_checker cdp_checker_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .port_serial_select_in(port_serial_select_in), .bus_style_select_in(bus_style_select_in),
    .reg_select_in(reg_select_in), .read_not_write_in(read_not_write_in), .strobe_e_in(strobe_e_in),
    .wr_n_in(wr_n_in), .rd_n_in(rd_n_in), .ser_cs_n_in(ser_cs_n_in), .db_out(db_out),
    .db_oe_n_out(db_oe_n_out), .busy_out(busy_out));

//--- cdp_host_model.sv
`timescale 1ns/1ps
module cdp_host_model (
    // clock and style
    input wire logic clk_in,
    input wire logic style_in,
    // bus
    input wire logic [7:0] rd_data_in,
    output logic rs_out,
    output logic rw_out,
    output logic e_out,
    output logic wr_n_out,
    output logic rd_n_out,
    output logic [7:0] db_out,
    // serial bus
    input wire logic ser_rd_in,
    output logic ser_cs_n_out,
    output logic ser_clk_out,
    output logic ser_dat_out
);
    logic nib_mode = 1'b0;
    initial begin
        rs_out = 1'b0;
        rw_out = 1'b0;
        e_out = 1'b0;
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        db_out = 8'h00;
        ser_cs_n_out = 1'b1;
        ser_clk_out = 1'b0;
        ser_dat_out = 1'b0;
    end
    // one frame: rs, rw, d7..d0; slow clock so the device's sync flops keep up
    task automatic ser(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
        logic [9:0] f;
        f = {rs, rw, d};
        q = 8'h00;
        @(posedge clk_in);
        ser_cs_n_out <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            ser_dat_out <= f[9 - i];
            ser_clk_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            ser_clk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            if (i >= 1 && i <= 8) q[8 - i] = ser_rd_in;
        end
        ser_cs_n_out <= 1'b1;
        ser_clk_out <= 1'b0;
        ser_dat_out <= ~f[0];
    endtask
    // data held long after the strobe: the device samples through sync flops
    task automatic cyc(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        rs_out <= rs;
        rw_out <= rw;
        db_out <= d;
        repeat (2) @(posedge clk_in);
        if (style_in) e_out <= 1'b1;
        else if (rw) rd_n_out <= 1'b0;
        else wr_n_out <= 1'b0;
        repeat (7) @(posedge clk_in);
        q = rd_data_in;
        e_out <= 1'b0;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        repeat (5) @(posedge clk_in);
        db_out <= ~d;
    endtask
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] hi;
        logic [7:0] lo;
        if (nib_mode) begin
            cyc(rs, rw, {d[7:4], 4'h5}, hi);
            cyc(rs, rw, {d[3:0], 4'hA}, lo);
            q = {hi[7:4], lo[7:4]};
        end else begin
            cyc(rs, rw, d, q);
        end
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'hFF;
        for (int i = 0; i < 40 && s[7]; i++) xfer(1'b0, 1'b1, 8'h00, s);
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench
    import cdp_pkg::*;
;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ser_sel = 1'b0;
    logic style = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, w;
    logic pready, pslverr, serr, rs, rw, e, wr_n, rd_n;
    logic [7:0] hdb, ddb, oe_n, q;
    logic busy, scs_n, sclk, sdo, sdi;
    wire [7:0] dbw = (~oe_n & ddb) | (oe_n & hdb);
    int fail_count = 0, cmp_count = 0;
    always #12.5 clk_in = ~clk_in;
    cdp_host_port cdp_host_port_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .port_serial_select_in(ser_sel),
        .bus_style_select_in(style), .reg_select_in(rs), .read_not_write_in(rw), .strobe_e_in(e), .wr_n_in(wr_n),
        .rd_n_in(rd_n), .db_in(dbw), .db_out(ddb), .db_oe_n_out(oe_n), .ser_cs_n_in(scs_n), .ser_clk_in(sclk),
        .ser_data_in(sdo), .ser_data_out(sdi), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .busy_out(busy));
    cdp_host_model cdp_host_model_inst (.clk_in(clk_in), .style_in(style), .rd_data_in(dbw), .rs_out(rs),
        .rw_out(rw), .e_out(e), .wr_n_out(wr_n), .rd_n_out(rd_n), .db_out(hdb), .ser_rd_in(sdi),
        .ser_cs_n_out(scs_n), .ser_clk_out(sclk), .ser_dat_out(sdo));
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        w = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic px(input logic s, input logic r, input logic [7:0] d);
        cdp_host_model_inst.xfer(s, r, d, q);
    endtask
    task automatic stat(input string n, input logic [7:0] exp);
        cdp_host_model_inst.wait_idle();
        px(1'b0, 1'b1, 8'h00);
        chk(n, {24'h0, q}, {24'h0, exp});
    endtask
    task automatic peek(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b1, OFS_PEEK, {24'h0, a});
        apb(1'b0, OFS_PEEK, 32'h0);
        chk("peek", w, exp);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        apb(1'b0, OFS_CFG, 32'h0);
        chk("cfg", w, 32'h0000_1801);
        apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", w, 32'h0000_4A00);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk("unmapped", {31'h0, serr}, 32'h1);
        $display("apb test done");
        px(1'b0, 1'b0, 8'h85);
        px(1'b0, 1'b1, 8'h00);
        chk("busy status", {24'h0, q}, 32'h85);
        chk("busy pin", {31'h0, busy}, 32'h1);
        stat("idle status", 8'h05);
        chk("busy pin idle", {31'h0, busy}, 32'h0);
        px(1'b1, 1'b0, 8'h41);
        stat("step up", 8'h06);
        peek(8'h05, 32'h4105);
        px(1'b1, 1'b0, 8'h42);
        px(1'b1, 1'b0, 8'h43);
        stat("dropped", 8'h07);
        peek(8'h06, 32'h4206);
        px(1'b0, 1'b0, 8'h04);
        cdp_host_model_inst.wait_idle();
        px(1'b1, 1'b0, 8'h44);
        stat("step down", 8'h06);
        px(1'b0, 1'b0, 8'h43);
        stat("glyph ac", 8'h03);
        px(1'b1, 1'b0, 8'h5A);
        stat("shared ac", 8'h02);
        peek(8'h83, 32'h5A83);
        px(1'b0, 1'b0, 8'h86);
        cdp_host_model_inst.wait_idle();
        px(1'b1, 1'b1, 8'h00);
        chk("data read", {24'h0, q}, 32'h42);
        $display("eight bit test done");
        ser_sel <= 1'b1;
        px(1'b0, 1'b0, 8'h80);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("serial pin", {31'h0, w[13]}, 32'h1);
        cdp_host_model_inst.ser(1'b1, 1'b0, 8'h66, q);
        repeat (40) @(posedge clk_in);
        cdp_host_model_inst.ser(1'b0, 1'b1, 8'h00, q);
        chk("serial status", {24'h0, q}, 32'h04);
        ser_sel <= 1'b0;
        repeat (4) @(posedge clk_in);
        stat("serial blocks", 8'h04);
        peek(8'h05, 32'h6605);
        $display("serial test done");
        px(1'b0, 1'b0, 8'h28);
        cdp_host_model_inst.nib_mode = 1'b1;
        cdp_host_model_inst.wait_idle();
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("width lines", {30'h0, w[10:9]}, 32'h2);
        px(1'b0, 1'b0, 8'hA5);
        stat("nibble status", 8'h25);
        style <= 1'b0;
        px(1'b1, 1'b0, 8'h77);
        stat("strobe style", 8'h24);
        peek(8'h25, 32'h7725);
        $display("four bit test done");
        apb(1'b1, OFS_CFG, 32'h0000_1800);
        px(1'b1, 1'b0, 8'h99);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("port off", {24'h0, w[7:0]}, 32'h24);
        apb(1'b1, OFS_CFG, 32'h0000_1801);
        $display("port enable test done");
        summarize();
    end
endmodule
